// ---- include/adc_sps_pkg.sv ----
// Shared constants for both ends of the converter's serial link.
// Assumes a 200 MHz system clock on both ends and a 22-bit command word.
package adc_sps_pkg;

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 22;
  localparam int READ_BITS = 18;
  localparam int PAD_BITS = 4;
  localparam logic [4:0] FRAME_BITS_CNT = 5'h16;
  localparam logic [4:0] CNT_SAT = 5'h1f;

  // ----------------------------------------------------------------
  // Input clock formats (polarity in bit 1, late capture phase in bit 0)
  // ----------------------------------------------------------------
  localparam logic [1:0] FMT_LOW_RISE = 2'h0;
  localparam logic [1:0] FMT_LOW_FALL = 2'h1;
  localparam logic [1:0] FMT_HIGH_FALL = 2'h2;
  localparam logic [1:0] FMT_HIGH_RISE = 2'h3;
  localparam logic [1:0] FMT_RESET = FMT_LOW_RISE;

  // ----------------------------------------------------------------
  // Output protocol register fields and codes
  // ----------------------------------------------------------------
  localparam int OC_MODE_LSB = 0;
  localparam int OC_WIDTH_LSB = 2;
  localparam int OC_DDR_BIT = 4;
  localparam int OC_CSEL_LSB = 6;
  localparam logic [7:0] OUT_CTRL_RESET = 8'h00;
  localparam logic [1:0] MODE_STD = 2'h0;
  localparam logic [1:0] MODE_EARLY = 2'h1;
  localparam logic [1:0] MODE_DEVCLK = 2'h3;
  localparam logic [1:0] WID_ONE = 2'h0;
  localparam logic [1:0] WID_TWO = 2'h2;
  localparam logic [1:0] WID_FOUR = 2'h3;
  localparam logic [1:0] CSEL_ECHO = 2'h0;

  // ----------------------------------------------------------------
  // Command word layout
  // ----------------------------------------------------------------
  localparam int OP_LSB = 18;
  localparam int ADDR_LSB = 8;
  localparam logic [3:0] OP_WRITE = 4'h1;
  localparam logic [9:0] ADDR_IN_PROTO = 10'h010;
  localparam logic [9:0] ADDR_OUT_PROTO = 10'h011;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_NS = 5;
  localparam int STROBE_HALF = 2;
  localparam int LINK_HALF_CYC = 8;
  localparam int READ_WINDOW_NS = 2000;

endpackage

// ---- include/adc_link_if.sv ----
// Serial link between the converter end and the host controller end.
// Every wire has a single driver, so no resolution is needed here.
`timescale 1ns/100ps
interface adc_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic [3:0] sdo;
  logic [3:0] sdo_oe;
  logic strobe;

  modport device(input cs_n, input sclk, input sdi, output sdo, output sdo_oe, output strobe);
  modport host(output cs_n, output sclk, output sdi, input sdo, input sdo_oe, input strobe);
endinterface

// ---- hw/adc_link_device.sv ----
// Converter end of the serial link, with its sample FIFO.
// Assumes link pins are asynchronous to sys_clk_i and the host keeps them
// static between frames.
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Sample FIFO
// ------------------------------------------------------------------
module sample_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Fill side.
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side.
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sample_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  // Flags are registered from the next count, so they are honest each cycle.
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;
  wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_data_o = mem[rd_ptr];

  // Storage needs no reset; the pointers decide what is valid.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers and flags.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= next_count;
      in_ready_o <= (next_count != (AW+1)'(DEPTH));
      out_valid_o <= (next_count != '0);
    end
  end
endmodule // sample_fifo

// ------------------------------------------------------------------
// Converter end
// ------------------------------------------------------------------
module adc_link_device #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Serial link.
  adc_link_if.device link,
  // Conversion results.
  input wire logic sample_valid_i,
  input wire logic [adc_sps_pkg::READ_BITS-1:0] sample_data_i,
  output logic sample_ready_o,
  // Decoded commands and live configuration.
  output logic cmd_valid_o,
  output logic [adc_sps_pkg::FRAME_BITS-1:0] cmd_word_o,
  output logic [1:0] in_format_o,
  output logic [7:0] out_ctrl_o
);
  import adc_sps_pkg::*;

  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic cs_last;
  logic sclk_last;
  logic [1:0] act_fmt;
  logic [1:0] pend_fmt;
  logic [7:0] out_ctrl;
  logic [FRAME_BITS-1:0] isr;
  logic [4:0] cap_cnt;
  logic [FRAME_BITS-1:0] odr;
  logic skip_first;
  logic [4:0] sh_left;
  logic [1:0] div_cnt;
  logic strobe_int;
  logic fifo_valid;
  logic [READ_BITS-1:0] fifo_data;
  logic [3:0] next_sdo;
  logic [3:0] next_oe;

  // ----------------------------------------------------------------
  // Pin decode and edge detection
  // ----------------------------------------------------------------
  wire cs_n_s = pin_sync[2];
  wire sclk_s = pin_sync[1];
  wire sdi_s = pin_sync[0];
  wire cs_fall = cs_last & ~cs_n_s;
  wire cs_rise = ~cs_last & cs_n_s;
  wire sclk_rise = ~sclk_last & sclk_s & ~cs_n_s;
  wire sclk_fall = sclk_last & ~sclk_s & ~cs_n_s;

  // Capture edge comes from the input format alone, never the output mode.
  wire cap_on_rise = (act_fmt == FMT_LOW_RISE) | (act_fmt == FMT_HIGH_RISE);
  wire late_phase = act_fmt[0];
  wire cap_edge = cap_on_rise ? sclk_rise : sclk_fall;
  wire launch_edge = cap_on_rise ? sclk_fall : sclk_rise;

  // ----------------------------------------------------------------
  // Output mode decode
  // ----------------------------------------------------------------
  wire [1:0] mode = out_ctrl[OC_MODE_LSB +: 2];
  wire [1:0] width = out_ctrl[OC_WIDTH_LSB +: 2];
  wire ddr = out_ctrl[OC_DDR_BIT];
  wire [1:0] csel = out_ctrl[OC_CSEL_LSB +: 2];
  // Early launch has no effect with a late capture phase.
  wire early = (mode == MODE_EARLY) & ~late_phase;
  wire devclk = (mode == MODE_DEVCLK);
  // Non-echo sources run a free divider; not usable for second-zone reads.
  wire int_clk = devclk & (csel != CSEL_ECHO);
  wire [2:0] lanes = (width == WID_FOUR) ? 3'h4 : (width == WID_TWO) ? 3'h2 : 3'h1;
  wire int_tick = int_clk & ~cs_n_s & (div_cnt == 2'(STROBE_HALF - 1)) &
                  ((sh_left != 5'h00) | strobe_int);
  wire int_fall = int_tick & strobe_int;

  // Early launch shifts on the capture edge, half a clock ahead.
  wire ext_shift = early ? cap_edge : (ddr ? (cap_edge | launch_edge) : launch_edge);
  wire shift_ev = int_clk ? (ddr ? int_tick : int_fall) : ext_shift;
  wire do_shift = shift_ev & ~skip_first & ~cs_n_s;
  wire [FRAME_BITS-1:0] odr_shifted = odr << lanes;

  // Command decode at frame end.
  wire frame_ok = (cap_cnt >= FRAME_BITS_CNT);
  wire is_write = (isr[OP_LSB +: 4] == OP_WRITE);
  wire wr_in = is_write & (isr[ADDR_LSB +: 10] == ADDR_IN_PROTO);
  wire wr_out = is_write & (isr[ADDR_LSB +: 10] == ADDR_OUT_PROTO);

  // Strobe: low in frame, echoes or generates the clock in device-clocked mode.
  wire next_strobe = cs_n_s ? 1'b1 : (devclk ? (int_clk ? strobe_int : sclk_s) : 1'b0);

  assign in_format_o = act_fmt;
  assign out_ctrl_o = out_ctrl;

  // Lane i carries bit i of the current group, MSB first on lane 0.
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign next_sdo[i] = (3'(i) < lanes) & odr[FRAME_BITS-1-i];
    assign next_oe[i] = ~cs_n_s & (3'(i) < lanes);
  end

  // ----------------------------------------------------------------
  // Sample buffer; one result is drained per frame start
  // ----------------------------------------------------------------
  sample_fifo #(
    .WIDTH(READ_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(sample_valid_i),
    .in_data_i(sample_data_i),
    .in_ready_o(sample_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(cs_fall)
  );

  // ----------------------------------------------------------------
  // Processes
  // ----------------------------------------------------------------

  // Two-stage synchronisers; edges are found on the second stage only.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_meta <= 3'h4;
      pin_sync <= 3'h4;
      cs_last <= 1'b1;
      sclk_last <= 1'b0;
    end else begin
      pin_meta <= {link.cs_n, link.sclk, link.sdi};
      pin_sync <= pin_meta;
      cs_last <= cs_n_s;
      sclk_last <= sclk_s;
    end
  end

  // Input shift register and capture counter.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      isr <= '0;
      cap_cnt <= 5'h00;
    end else if (cs_fall) begin
      isr <= '0;
      cap_cnt <= 5'h00;
    end else if (cap_edge) begin
      isr <= {isr[FRAME_BITS-2:0], sdi_s};
      cap_cnt <= (cap_cnt == CNT_SAT) ? cap_cnt : cap_cnt + 5'h01;
    end
  end

  // Command processing; short frames change nothing.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      act_fmt <= FMT_RESET;
      pend_fmt <= FMT_RESET;
      out_ctrl <= OUT_CTRL_RESET;
      cmd_valid_o <= 1'b0;
      cmd_word_o <= '0;
    end else begin
      cmd_valid_o <= cs_rise & frame_ok & ~wr_in & ~wr_out;
      if (cs_rise & frame_ok) begin
        cmd_word_o <= isr;
      end
      if (cs_rise & frame_ok & wr_in) begin
        pend_fmt <= isr[1:0];
      end
      if (cs_rise & frame_ok & wr_out) begin
        out_ctrl <= isr[7:0];
      end
      // The running frame keeps its format until chip select falls again.
      if (cs_fall) begin
        act_fmt <= pend_fmt;
      end
    end
  end

  // Output data register and the internal strobe divider.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      odr <= '0;
      skip_first <= 1'b0;
      sh_left <= 5'h00;
      div_cnt <= 2'h0;
      strobe_int <= 1'b0;
    end else if (cs_fall) begin
      odr <= fifo_valid ? {fifo_data, {PAD_BITS{1'b0}}} : '0;
      // Without DDR or device clocking, a late phase keeps the MSB on the lanes through the first launch edge, skipping that shift.
      // The frame that starts now runs in the pending format, so take its phase
      // from there; early launch never applies with a late phase.
      skip_first <= pend_fmt[0] & ~devclk & ~ddr;
      sh_left <= FRAME_BITS_CNT;
      div_cnt <= 2'h0;
      strobe_int <= 1'b0;
    end else begin
      if (shift_ev) begin
        skip_first <= 1'b0;
      end
      if (do_shift) begin
        odr <= odr_shifted;
        sh_left <= (sh_left > {2'h0, lanes}) ? sh_left - {2'h0, lanes} : 5'h00;
      end
      if (int_clk & ~cs_n_s) begin
        div_cnt <= int_tick ? 2'h0 : div_cnt + 2'h1;
        strobe_int <= int_tick ? ~strobe_int : strobe_int;
      end
    end
  end

  // Registered pin drivers.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link.sdo <= 4'h0;
      link.sdo_oe <= 4'h0;
      link.strobe <= 1'b1;
    end else begin
      link.sdo <= next_sdo;
      link.sdo_oe <= next_oe;
      link.strobe <= next_strobe;
    end
  end
endmodule // adc_link_device

// ---- hw/adc_link_host.sv ----
// Host controller end of the serial link.
// Assumes the converter end runs on a clock of the same rate; reads are
// captured in the standard and wider-bus protocols only.
`timescale 1ns/100ps
module adc_link_host #(
  parameter int HALF_CYC = adc_sps_pkg::LINK_HALF_CYC,
  parameter int READ_WINDOW_NS = adc_sps_pkg::READ_WINDOW_NS
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Serial link.
  adc_link_if.host link,
  // Frame requests.
  input wire logic req_valid_i,
  input wire logic [adc_sps_pkg::FRAME_BITS-1:0] req_word_i,
  input wire logic [5:0] req_clocks_i,
  output logic req_ready_o,
  // Read results and tracked format.
  output logic rx_valid_o,
  output logic [adc_sps_pkg::FRAME_BITS-1:0] rx_word_o,
  output logic [1:0] fmt_o
);
  import adc_sps_pkg::*;

  // Longest read time rounds down to whole cycles.
  localparam int READ_WINDOW_CYC = READ_WINDOW_NS / SYS_CLK_NS;

  // An optimal read must fit the zone's window; slow clocks are refused.
  if (READ_BITS * 2 * HALF_CYC + HALF_CYC > READ_WINDOW_CYC) begin : g_slow
    $error("adc_link_host clock too slow for the read window");
  end
  // Both ends sync the pins, so a half period must cover that latency.
  if (HALF_CYC < 8 || HALF_CYC > 255) begin : g_half
    $error("adc_link_host half period out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_GAP = 3'b100
  } state_e;

  state_e state;
  logic [1:0] fmt;
  logic [1:0] width;
  logic [FRAME_BITS-1:0] word;
  logic [FRAME_BITS-1:0] tx;
  logic [5:0] clocks;
  logic [6:0] edge_cnt;
  logic [7:0] hc;
  logic [3:0] sdo_meta;
  logic [3:0] sdo_sync;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire late_phase = fmt[0];
  wire half_done = (hc == 8'(HALF_CYC - 1));
  wire last_edge = (edge_cnt == {clocks, 1'b0});
  wire first_of_clock = ~edge_cnt[0];
  wire cap_now = late_phase ? ~first_of_clock : first_of_clock;
  wire is_write = (word[OP_LSB +: 4] == OP_WRITE);
  wire long_enough = ({1'b0, clocks} >= {2'h0, FRAME_BITS_CNT});
  wire req_wr_out = (req_word_i[OP_LSB +: 4] == OP_WRITE) &
                    (req_word_i[ADDR_LSB +: 10] == ADDR_OUT_PROTO);
  // Device clocking is only safe with the echo source in either zone.
  wire force_echo = req_wr_out & (req_word_i[OC_MODE_LSB +: 2] == MODE_DEVCLK);
  wire [FRAME_BITS-1:0] req_fixed = force_echo ?
      {req_word_i[FRAME_BITS-1:OC_CSEL_LSB+2], CSEL_ECHO, req_word_i[OC_CSEL_LSB-1:0]} :
      req_word_i;
  wire [FRAME_BITS-1:0] rx_one = {rx_word_o[FRAME_BITS-2:0], sdo_sync[0]};
  wire [FRAME_BITS-1:0] rx_two = {rx_word_o[FRAME_BITS-3:0], sdo_sync[0], sdo_sync[1]};
  wire [FRAME_BITS-1:0] rx_four = {rx_word_o[FRAME_BITS-5:0], sdo_sync[0], sdo_sync[1],
                                   sdo_sync[2], sdo_sync[3]};
  wire [FRAME_BITS-1:0] rx_next = (width == WID_FOUR) ? rx_four :
                                  (width == WID_TWO) ? rx_two : rx_one;

  assign fmt_o = fmt;

  // ----------------------------------------------------------------
  // Processes
  // ----------------------------------------------------------------

  // Output lines come back from the other end; sync them first.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sdo_meta <= 4'h0;
      sdo_sync <= 4'h0;
    end else begin
      sdo_meta <= link.sdo;
      sdo_sync <= sdo_meta;
    end
  end

  // Frame sequencer; the clock is a divider of sys_clk_i.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_IDLE;
      fmt <= FMT_RESET;
      width <= WID_ONE;
      word <= '0;
      tx <= '0;
      clocks <= 6'h00;
      edge_cnt <= 7'h00;
      hc <= 8'h00;
      req_ready_o <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_word_o <= '0;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.sdi <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          // Lines stay static while no frame runs.
          req_ready_o <= 1'b1;
          if (req_valid_i & req_ready_o) begin
            req_ready_o <= 1'b0;
            state <= ST_SHIFT;
            word <= req_fixed;
            clocks <= req_clocks_i;
            edge_cnt <= 7'h00;
            hc <= 8'h00;
            rx_word_o <= '0;
            link.cs_n <= 1'b0;
            // Current format is the default until a format write has landed.
            if (!late_phase) begin
              link.sdi <= req_fixed[FRAME_BITS-1];
              tx <= req_fixed << 1;
            end else begin
              tx <= req_fixed;
            end
          end
        end
        ST_SHIFT: begin
          hc <= half_done ? 8'h00 : hc + 8'h01;
          if (half_done & last_edge) begin
            link.cs_n <= 1'b1;
            rx_valid_o <= 1'b1;
            state <= ST_GAP;
            // Track what the device will now expect from us.
            if (is_write & long_enough & (word[ADDR_LSB +: 10] == ADDR_IN_PROTO)) begin
              fmt <= word[1:0];
            end
            if (is_write & long_enough & (word[ADDR_LSB +: 10] == ADDR_OUT_PROTO)) begin
              width <= word[OC_WIDTH_LSB +: 2];
            end
          end else if (half_done) begin
            link.sclk <= ~link.sclk;
            edge_cnt <= edge_cnt + 7'h01;
            if (cap_now) begin
              rx_word_o <= rx_next;
            end else begin
              link.sdi <= tx[FRAME_BITS-1];
              tx <= tx << 1;
            end
          end
        end
        ST_GAP: begin
          // Idle level follows the format in force for the next frame.
          link.sclk <= fmt[1];
          hc <= half_done ? 8'h00 : hc + 8'h01;
          if (half_done) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule // adc_link_host

// ---- verification/adc_link_monitor.sv ----
// Checker for the serial wires that join the converter end and the host end.
// Assumes the bench places it beside the link interface and never uses device-clock reads.
`timescale 1ns/100ps
module adc_link_monitor (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Link wires.
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic [3:0] sdo,
  input wire logic [3:0] sdo_oe,
  input wire logic strobe
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  // The strobe frames each transfer; the pin is synchronised, so a few cycles of lag are allowed.
  strobe_drop_a: assert property ($fell(cs_n) |-> ##[2:6] !strobe)
    else $error("strobe did not fall after frame start");
  strobe_rise_a: assert property ($rose(cs_n) |-> ##[2:8] strobe)
    else $error("strobe did not rise after frame end");
  strobe_low_a: assert property ((!cs_n) [*8] |-> !strobe)
    else $error("strobe high inside a standard frame");

  // The lanes are owned by the converter only inside a frame.
  lanes_free_a: assert property (cs_n [*8] |-> sdo_oe == 4'h0)
    else $error("data lane driven outside a frame");
  lane_drive_a: assert property ((!cs_n) [*8] |-> sdo_oe[0])
    else $error("first data lane not driven inside a frame");

  // Host side: serial clock half period of eight cycles, quiet lines between frames.
  sclk_half_a: assert property ($changed(sclk) |=> $stable(sclk) [*7])
    else $error("serial clock half period too short");
  frame_gap_a: assert property ($rose(cs_n) |=> cs_n [*7])
    else $error("chip select gap too short");
  sdi_quiet_a: assert property (cs_n && $past(cs_n) |-> $stable(sdi))
    else $error("input data moved between frames");

  // Main scenarios: frames end, and wide lanes are used.
  cover property ($rose(cs_n));
  cover property (!cs_n && sdo_oe == 4'h3);
  cover property (!cs_n && sdo_oe == 4'hf && sdo != 4'h0);
endmodule // adc_link_monitor

// ---- verification/adc_serial_protocol_select_bench.sv ----
// Bench joining both link ends; drives host requests and converter samples.
// Assumes the package defaults: 22-bit words, eight-cycle serial half period.
`timescale 1ns/100ps
module adc_serial_protocol_select_bench;
  import adc_sps_pkg::*;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic [FRAME_BITS-1:0] req_word_i = '0;
  logic [5:0] req_clocks_i = 6'h00;
  logic sample_valid_i = 1'b0;
  logic [READ_BITS-1:0] sample_data_i = '0;
  logic req_ready_o, rx_valid_o, sample_ready_o, cmd_valid_o;
  logic [FRAME_BITS-1:0] rx_word_o, cmd_word_o, last_cmd;
  logic [1:0] in_format_o, fmt_o;
  logic [7:0] out_ctrl_o;
  logic [1:0] wid [3] = '{WID_ONE, WID_TWO, WID_FOUR};
  int lanes [3] = '{1, 2, 4};
  int clks [3] = '{18, 9, 5};
  int fail_count = 0;
  int n_compared = 0;
  int pops = 0;
  int cycles = 0;
  int frame_cyc = 0;

  adc_link_if adc_link_if_inst ();
  adc_link_device adc_link_device_inst (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .link(adc_link_if_inst.device), .sample_valid_i(sample_valid_i),
    .sample_data_i(sample_data_i), .sample_ready_o(sample_ready_o), .cmd_valid_o(cmd_valid_o),
    .cmd_word_o(cmd_word_o), .in_format_o(in_format_o), .out_ctrl_o(out_ctrl_o));
  adc_link_host adc_link_host_inst (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .link(adc_link_if_inst.host), .req_valid_i(req_valid_i), .req_word_i(req_word_i),
    .req_clocks_i(req_clocks_i), .req_ready_o(req_ready_o), .rx_valid_o(rx_valid_o),
    .rx_word_o(rx_word_o), .fmt_o(fmt_o));
  adc_link_monitor adc_link_monitor_inst (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .cs_n(adc_link_if_inst.cs_n), .sclk(adc_link_if_inst.sclk), .sdi(adc_link_if_inst.sdi),
    .sdo(adc_link_if_inst.sdo), .sdo_oe(adc_link_if_inst.sdo_oe),
    .strobe(adc_link_if_inst.strobe));

  // System clock, 5 ns period.
  always #2.5 sys_clk_i = ~sys_clk_i;

  // Records decoded commands and cuts a hang short; 22-clock frames take about 400 cycles each.
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cmd_valid_o === 1'b1) begin
      last_cmd <= cmd_word_o;
    end
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [FRAME_BITS-1:0] got, input logic [FRAME_BITS-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [FRAME_BITS-1:0] wr(input logic [9:0] a, input logic [7:0] d);
    return {OP_WRITE, a, d};
  endfunction

  function automatic logic [READ_BITS-1:0] samp(input int i);
    return 18'h2_c35a ^ READ_BITS'(i);
  endfunction

  // One host frame: request held until taken, then wait for the frame end and decode.
  task automatic send(input logic [FRAME_BITS-1:0] word, input int clocks);
    req_valid_i <= 1'b1;
    req_word_i <= word;
    req_clocks_i <= 6'(clocks);
    do @(posedge sys_clk_i); while (req_ready_o !== 1'b1);
    req_valid_i <= 1'b0;
    frame_cyc = cycles;
    do @(posedge sys_clk_i); while (rx_valid_o !== 1'b1);
    // Cycles from the accepting edge to the edge that sees the end pulse.
    frame_cyc = cycles - frame_cyc;
    pops++;
    repeat (12) @(posedge sys_clk_i);
  endtask

  task automatic t_reset();
    chk(in_format_o, FMT_RESET);
    chk(out_ctrl_o, OUT_CTRL_RESET);
    chk(fmt_o, FMT_RESET);
    $display("test reset done");
  endtask

  // Each new format is written in the old one and takes hold only from the next frame.
  task automatic t_formats();
    for (int f = 1; f < 4; f++) begin
      send(wr(ADDR_IN_PROTO, 8'(f)), 22);
      chk(in_format_o, 22'(f - 1));
      send(22'h2a_5c00 ^ 22'(f), 22);
      chk(in_format_o, 22'(f));
      chk(last_cmd, 22'h2a_5c00 ^ 22'(f));
    end
    $display("test formats done");
  endtask

  // Frames one clock short must leave configuration and commands alone.
  task automatic t_short();
    last_cmd = '0;
    send(wr(ADDR_OUT_PROTO, 8'h0c), 21);
    chk(out_ctrl_o, OUT_CTRL_RESET);
    send(22'h2b_1100, 21);
    chk(last_cmd, 22'h00_0000);
    $display("test short done");
  endtask

  // Fill the sample buffer until it refuses, then read it back on one, two and four lanes.
  task automatic t_fifo_reads();
    int n;
    int k;
    n = 0;
    sample_valid_i <= 1'b1;
    sample_data_i <= samp(0);
    repeat (12) begin
      @(posedge sys_clk_i);
      if (sample_ready_o === 1'b1) begin
        n++;
        sample_data_i <= samp(n);
      end
    end
    sample_valid_i <= 1'b0;
    chk(22'(n), 22'h00_0008);
    pops = 0;
    for (int w = 0; w < 3; w++) begin
      send(wr(ADDR_OUT_PROTO, {4'h0, wid[w], 2'h0}), 22);
      chk(out_ctrl_o, {14'h0000, wid[w], 2'h0});
      k = pops;
      send(22'h00_0000, clks[w]);
      chk(rx_word_o, {samp(k), 4'h0} >> (22 - clks[w] * lanes[w]));
      // A read of N clocks lasts 2N+1 half periods plus the end pulse.
      chk(22'(frame_cyc), 22'((2 * clks[w] + 1) * LINK_HALF_CYC + 1));
      chk(22'(frame_cyc * SYS_CLK_NS <= READ_WINDOW_NS), 22'h00_0001);
    end
    $display("test buffer reads done");
  endtask

  // Output modes; device clocking is written last since the host cannot read it back.
  task automatic t_modes();
    send(wr(ADDR_OUT_PROTO, 8'h01), 22);
    chk(out_ctrl_o, 22'h00_0001);
    send(wr(ADDR_OUT_PROTO, 8'h1c), 22);
    chk(out_ctrl_o, 22'h00_001c);
    send(wr(ADDR_OUT_PROTO, 8'h83), 22);
    chk(out_ctrl_o, 22'h00_0003);
    $display("test modes done");
  endtask

  // Main sequence after a 20-cycle reset.
  initial begin
    repeat (20) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    t_reset();
    t_formats();
    t_short();
    t_fifo_reads();
    t_modes();
    report_and_stop();
  end
endmodule // adc_serial_protocol_select_bench
